// [psrc_pkg.sv]
// Package with types and constants for the switch reset controller.
package psrc_pkg;

  // ==========================================================================
  // Sizes and timing
  // ==========================================================================
  localparam int NUM_PORTS_DEF = 8;
  // Time from PLL lock to core reset release, in nanoseconds.
  localparam int LOCK_TO_CORE_NS = 33000;
  localparam int CLK_PERIOD_NS   = 10;
  // Least time: round up to whole cycles.
  localparam int LOCK_TO_CORE_CYC =
    (LOCK_TO_CORE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_W = 16;
  localparam logic [DLY_W-1:0] DLY_RESET = 16'h0000;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    PSRC_IN_RESET,
    PSRC_WAIT_LOCK,
    PSRC_LOCK_DELAY,
    PSRC_RUN
  } psrc_state_t;

  // Upstream link events, same clock domain.
  typedef struct packed {
    logic hot_reset_ts;
    logic dl_inactive;
  } psrc_up_evt_t;

  // Per-port reset actions.
  typedef struct packed {
    logic port_rst;
    logic send_hot_reset;
    logic drop_rx;
    logic drain_queues;
  } psrc_port_act_t;

endpackage : psrc_pkg

// [psrc_sync.sv]
// Two-flop synchroniser for an active-low asynchronous reset pin.
`timescale 1ns/1ps
module psrc_sync (
  input  wire logic clk_i,
  input  wire logic async_n_i,
  output logic      sync_n_o
);
  import psrc_pkg::*;

  logic meta_reg;

  // Asserts as soon as the pin is low, releases through two flops.
  always_ff @(posedge clk_i or negedge async_n_i) begin
    if (!async_n_i) begin
      meta_reg <= 1'b0;
      sync_n_o <= 1'b0;
    end else begin
      meta_reg <= 1'b1;
      sync_n_o <= meta_reg;
    end
  end

endmodule // psrc_sync

// [psrc_reset_ctrl.sv]
// Reset controller for a multi-port switch: fundamental, hot and bus resets.
// Operation
// - Bridge bus-reset bit resets its downstream hierarchy.
// - Fundamental reset exit restores all start-up values.
// - Low reset pin places whole device in reset.
// - Warm reset reruns full initialization after release.
// - Hot reset drops packets, resets non-sticky state.
// - Hot reset spares clocks, configuration, sticky bits.
// - Reset training sets or link-down start hot reset.
// - Downstream ports send reset ordered-sets downstream.
// - Upstream hot reset reaches every downstream bridge.
// - Ignore bit blocks upstream hot reset propagation.
// - Upstream bus-reset resets every downstream port.
// - Upstream bridge untouched, downstream queues drained.
// - Downstream bus-reset: hot reset, drop its traffic.
// - Link held in reset until bit cleared.
// - Drained queues handled like link-down.
// - Core reset released 33 us after lock.
`timescale 1ns/1ps
module psrc_reset_ctrl #(
  parameter int NUM_PORTS  = psrc_pkg::NUM_PORTS_DEF,
  parameter int LOCK_DELAY = psrc_pkg::LOCK_TO_CORE_CYC
) (
  input  wire logic                   clk_i,
  input  wire logic                   sys_rst_i,
  input  wire logic                   fundamental_reset_n,
  input  wire logic                   pll_lock_i,
  input  wire psrc_pkg::psrc_up_evt_t up_evt_i,
  input  wire logic                   upstream_reset_ignore,
  input  wire logic                   up_sec_bus_reset_i,
  input  wire logic [NUM_PORTS-1:0]   dn_sec_bus_reset_i,
  output logic                        fund_rst_o,
  output logic                        core_rst_o,
  output logic                        up_hot_rst_o,
  output logic                        up_drain_o,
  output psrc_pkg::psrc_port_act_t [NUM_PORTS-1:0] port_act_o
);
  import psrc_pkg::*;

  // ==========================================================================
  // Fundamental reset synchronisation
  // ==========================================================================
  logic perst_sync_n;
  logic lock_s1_reg;
  logic lock_s2_reg;

  psrc_sync u_sync (
    .clk_i     (clk_i),
    .async_n_i (fundamental_reset_n),
    .sync_n_o  (perst_sync_n)
  );

  always_ff @(posedge clk_i) begin
    lock_s1_reg <= pll_lock_i;
    lock_s2_reg <= lock_s1_reg;
  end

  wire logic fund_active = sys_rst_i | ~perst_sync_n;

  // ==========================================================================
  // Start-up sequencing
  // ==========================================================================
  psrc_state_t      state_reg;
  psrc_state_t      state_next;
  logic [DLY_W-1:0] dly_reg;
  logic [DLY_W-1:0] dly_next;

  wire logic dly_done = (dly_reg == DLY_W'(LOCK_DELAY - 1));

  always_comb begin
    state_next = state_reg;
    dly_next   = dly_reg;
    case (state_reg)
      PSRC_IN_RESET: begin
        state_next = PSRC_WAIT_LOCK;
      end
      PSRC_WAIT_LOCK: begin
        dly_next = DLY_RESET;
        if (lock_s2_reg) begin
          state_next = PSRC_LOCK_DELAY;
        end
      end
      PSRC_LOCK_DELAY: begin
        dly_next = dly_reg + 16'h0001;
        if (!lock_s2_reg) begin
          state_next = PSRC_WAIT_LOCK;
        end else if (dly_done) begin
          state_next = PSRC_RUN;
        end
      end
      PSRC_RUN: begin
        state_next = PSRC_RUN;
      end
      default: begin
        state_next = PSRC_IN_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (fund_active) begin
      state_reg <= PSRC_IN_RESET;
      dly_reg   <= DLY_RESET;
    end else begin
      state_reg <= state_next;
      dly_reg   <= dly_next;
    end
  end

  wire logic running = (state_reg == PSRC_RUN);

  // ==========================================================================
  // Hot reset decode
  // ==========================================================================
  // The ignore bit is configuration state, so a hot reset never clears it.
  wire logic up_trig = (up_evt_i.hot_reset_ts | up_evt_i.dl_inactive)
                       & ~upstream_reset_ignore;
  wire logic up_hot  = running & up_trig;
  wire logic up_sbr  = running & up_sec_bus_reset_i;

  psrc_port_act_t [NUM_PORTS-1:0] act_next;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
      wire logic dn_sbr = running & dn_sec_bus_reset_i[gi];
      // Bus-reset bits hold the link in reset for as long as set.
      wire logic any_rst = up_hot | up_sbr | dn_sbr;
      assign act_next[gi].port_rst       = any_rst;
      assign act_next[gi].send_hot_reset = any_rst;
      assign act_next[gi].drop_rx        = any_rst;
      assign act_next[gi].drain_queues   = any_rst;
    end
  endgenerate

  // ==========================================================================
  // Output registers
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (fund_active) begin
      fund_rst_o   <= 1'b1;
      core_rst_o   <= 1'b1;
      up_hot_rst_o <= 1'b0;
      up_drain_o   <= 1'b0;
      port_act_o   <= '0;
    end else begin
      fund_rst_o   <= 1'b0;
      core_rst_o   <= ~running;
      up_hot_rst_o <= up_hot;
      // Upstream bridge stays up during its own bus reset.
      up_drain_o   <= up_hot | up_sbr;
      port_act_o   <= act_next;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_lock_held;
    lock_s2_reg && state_reg == PSRC_LOCK_DELAY;
  endsequence

  sequence s_lock_lost;
    !lock_s2_reg && state_reg == PSRC_LOCK_DELAY;
  endsequence

  a_core_release: assert property (@(posedge clk_i) disable iff (fund_active)
    $fell(core_rst_o) |-> $past(state_reg) == PSRC_RUN)
    else $error("core reset released before delay expired");

  a_delay_len: assert property (@(posedge clk_i) disable iff (fund_active)
    (dly_done and s_lock_held) |=> state_reg == PSRC_RUN)
    else $error("lock delay did not end in run");

  a_pin_reset: assert property (@(posedge clk_i)
    !perst_sync_n |=> fund_rst_o && core_rst_o && port_act_o == '0)
    else $error("pin low did not reset device");

  a_warm_rerun: assert property (@(posedge clk_i)
    fund_active |=> state_reg == PSRC_IN_RESET)
    else $error("warm reset did not restart sequence");

  a_hot_follow: assert property (@(posedge clk_i) disable iff (fund_active)
    up_hot |=> up_hot_rst_o && port_act_o[0].send_hot_reset)
    else $error("upstream hot reset not forwarded");

  a_ignore_blk: assert property (@(posedge clk_i) disable iff (fund_active)
    (upstream_reset_ignore && !up_sec_bus_reset_i
     && dn_sec_bus_reset_i == '0) |=> !port_act_o[0].port_rst)
    else $error("hot reset passed while ignored");

  a_sbr_hold: assert property (@(posedge clk_i) disable iff (fund_active)
    (running && dn_sec_bus_reset_i[0]) |=> port_act_o[0].send_hot_reset)
    else $error("bus reset link not held");

  a_up_untouched: assert property (@(posedge clk_i) disable iff (fund_active)
    (up_sbr && !up_hot) |=> !up_hot_rst_o && up_drain_o)
    else $error("upstream bridge touched by bus reset");

  a_hot_release: assert property (@(posedge clk_i) disable iff (fund_active)
    (running && !up_trig && !up_sec_bus_reset_i
     && dn_sec_bus_reset_i == '0) |=> port_act_o == '0)
    else $error("port reset held without trigger");

  a_lock_loss: assert property (@(posedge clk_i) disable iff (fund_active)
    s_lock_lost |=> state_reg == PSRC_WAIT_LOCK)
    else $error("lock loss did not return to waiting");

  a_hot_core: assert property (@(posedge clk_i) disable iff (fund_active)
    up_hot |=> !core_rst_o && !fund_rst_o)
    else $error("hot reset disturbed core reset");

  a_dn_local: assert property (@(posedge clk_i) disable iff (fund_active)
    (running && dn_sec_bus_reset_i[0] && !dn_sec_bus_reset_i[1]
     && !up_trig && !up_sec_bus_reset_i)
    |=> port_act_o[1] == '0 && !up_hot_rst_o)
    else $error("bus reset leaked to another port");

  a_up_sbr_all: assert property (@(posedge clk_i) disable iff (fund_active)
    up_sbr |=> port_act_o[NUM_PORTS-1].send_hot_reset
               && port_act_o[NUM_PORTS-1].drain_queues)
    else $error("upstream bus reset missed a port");

endmodule // psrc_reset_ctrl

// [psrc_up_port_model.sv]
// Behavioural model of the upstream port that sends link reset events.
`timescale 1ns/1ps
module psrc_up_port_model (
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             send_ts_i,
  input  wire logic             link_down_i,
  output psrc_pkg::psrc_up_evt_t evt_o
);
  import psrc_pkg::*;

  // ==========================================================================
  // Event drive
  // ==========================================================================
  // Events are levels that stand as long as the partner keeps sending them.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      evt_o <= '0;
    end else begin
      evt_o.hot_reset_ts <= send_ts_i;
      evt_o.dl_inactive  <= link_down_i;
    end
  end
endmodule // psrc_up_port_model

// [pcie_switch_reset_control_tb_top.sv]
// Self-checking testbench for the switch reset controller.
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
  begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
  $display("FAIL %0t %s", $time, msg); end end
module pcie_switch_reset_control_tb_top;
  import psrc_pkg::*;
  localparam int NP = 4;
  localparam int LD = 5;
  logic clk_i = 0, sys_rst_i = 1, fundamental_reset_n = 1, pll_lock_i = 0;
  logic ign = 0, up_sbr = 0, send_ts = 0, link_down = 0;
  logic [NP-1:0] dn_sbr = '0;
  psrc_up_evt_t up_evt;
  logic fund_rst_o, core_rst_o, up_hot_rst_o, up_drain_o;
  psrc_port_act_t [NP-1:0] port_act_o;
  int mismatches = 0, comparisons = 0;

  always #5 clk_i = ~clk_i;

  psrc_up_port_model up (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .send_ts_i(send_ts), .link_down_i(link_down), .evt_o(up_evt));
  psrc_reset_ctrl #(.NUM_PORTS(NP), .LOCK_DELAY(LD)) dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .fundamental_reset_n(fundamental_reset_n), .pll_lock_i(pll_lock_i),
    .up_evt_i(up_evt), .upstream_reset_ignore(ign),
    .up_sec_bus_reset_i(up_sbr), .dn_sec_bus_reset_i(dn_sbr),
    .fund_rst_o(fund_rst_o), .core_rst_o(core_rst_o),
    .up_hot_rst_o(up_hot_rst_o), .up_drain_o(up_drain_o),
    .port_act_o(port_act_o));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic results();
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Raises lock and counts cycles until the core leaves reset.
  task automatic lock_and_release();
    int n;
    n = 0;
    pll_lock_i = 1;
    while (core_rst_o !== 1'b0 && n < 60) begin
      cyc(1);
      n++;
    end
    if (n >= 60) begin
      mismatches++;
      results();
    end
    `CHK(n >= LD && n <= LD + 8, 1'b1, "core release delay")
    `CHK(fund_rst_o, 1'b0, "fundamental reset still high")
    `CHK({up_hot_rst_o, up_drain_o, port_act_o}, '0, "outputs not idle")
  endtask

  task automatic check_idle(input string msg);
    `CHK({up_hot_rst_o, up_drain_o, port_act_o}, '0, msg)
  endtask

  task automatic t_dn_bus_reset();
    dn_sbr = 4'h2;
    cyc(3);
    `CHK(port_act_o, 16'h00f0, "port 1 actions")
    `CHK({up_hot_rst_o, up_drain_o}, 2'h0, "upstream touched")
    cyc(20);
    `CHK(port_act_o[1], 4'hf, "link let go early")
    dn_sbr = 4'h9;
    cyc(3);
    `CHK(port_act_o, 16'hf00f, "ports 0 and 3 actions")
    dn_sbr = '0;
    cyc(3);
    check_idle("bus reset not released");
  endtask

  task automatic t_up_hot(input logic ts, input logic dl);
    send_ts = ts;
    link_down = dl;
    cyc(4);
    `CHK(up_hot_rst_o, 1'b1, "hot reset missing")
    `CHK(up_drain_o, 1'b1, "drain missing")
    `CHK(port_act_o, 16'hffff, "not propagated")
    cyc(10);
    `CHK(up_hot_rst_o, 1'b1, "hot reset dropped")
    `CHK(fund_rst_o | core_rst_o, 1'b0, "core disturbed")
    send_ts = 0;
    link_down = 0;
    cyc(4);
    check_idle("hot reset not released");
  endtask

  task automatic t_ignore();
    ign = 1;
    send_ts = 1;
    link_down = 1;
    cyc(5);
    check_idle("ignored event acted");
    dn_sbr = 4'h4;
    cyc(3);
    `CHK(port_act_o, 16'h0f00, "bus reset blocked")
    dn_sbr = '0;
    send_ts = 0;
    link_down = 0;
    cyc(3);
    ign = 0;
  endtask

  task automatic t_up_bus_reset();
    up_sbr = 1;
    cyc(3);
    `CHK(up_drain_o, 1'b1, "no drain")
    `CHK(up_hot_rst_o, 1'b0, "upstream bridge touched")
    `CHK(port_act_o, 16'hffff, "ports not reset")
    up_sbr = 0;
    cyc(3);
    check_idle("upstream bus reset not released");
  endtask

  task automatic t_warm_reset();
    fundamental_reset_n = 0;
    dn_sbr = 4'h1;
    cyc(3);
    `CHK({fund_rst_o, core_rst_o}, 2'h3, "pin low not in reset")
    `CHK(port_act_o, '0, "acted during reset")
    pll_lock_i = 0;
    cyc(5);
    fundamental_reset_n = 1;
    dn_sbr = '0;
    cyc(4);
    `CHK(core_rst_o, 1'b1, "core left reset without lock")
    pll_lock_i = 1;
    cyc(4);
    pll_lock_i = 0;
    cyc(6);
    `CHK(core_rst_o, 1'b1, "core left reset after lock loss")
    lock_and_release();
  endtask

  initial begin
    cyc(12);
    `CHK({fund_rst_o, core_rst_o}, 2'h3, "reset values")
    sys_rst_i = 0;
    cyc(3);
    lock_and_release();
    t_dn_bus_reset();
    t_up_hot(1, 0);
    t_up_hot(0, 1);
    t_ignore();
    t_up_bus_reset();
    t_warm_reset();
    t_up_hot(1, 1);
    results();
  end
endmodule // pcie_switch_reset_control_tb_top
